// *** ptpc_far_side.sv ***
/* far-side model: pad ring for both ports and the converter's sampler.
   assumes outside levels come from the bench, one clk domain. */
`timescale 1ns/1ps
module ptpc_far_side (
   // clock
   input  wire logic       clk,
   // block pad drive
   input  wire logic [7:0] portAOut,
   input  wire logic [7:0] portAOutEn,
   input  wire logic [7:0] portBOut,
   input  wire logic [7:0] portBOutEn,
   // outside levels and converter link
   input  wire logic [7:0] extA,
   input  wire logic [7:0] extB,
   input  wire logic [3:0] convChannel,
   input  wire logic       convChannelValid,
   // resolved pads and converter result
   output logic      [7:0] portAIn,
   output logic      [7:0] portBIn,
   output logic            convSample
);
   // a driven pad shows the block's level, else the outside level
   assign portAIn = (portAOutEn & portAOut) | (~portAOutEn & extA);
   assign portBIn = (portBOutEn & portBOut) | (~portBOutEn & extB);
   // converter takes the selected pin only while the channel is valid
   always @(posedge clk) begin
      if (convChannelValid) convSample <= portAIn[convChannel[2:0]];
   end
endmodule

// *** ptpc_pin_cell.sv ***
/*
 one general-purpose pin cell: direction, latch, pull-up and readback selection.
 assumes pin input already synchronous to clk.
*/
`timescale 1ns/1ps
module ptpc_pin_cell #(
   parameter int unsigned WIDTH = 8
) (
   // pin state
   input  wire logic [WIDTH-1:0] dirInput,
   input  wire logic [WIDTH-1:0] latchVal,
   input  wire logic [WIDTH-1:0] pullupCfg,
   input  wire logic [WIDTH-1:0] digitalOk,
   input  wire logic [WIDTH-1:0] pinIn,
   // derived
   output logic      [WIDTH-1:0] outEn,
   output logic      [WIDTH-1:0] pullupOn,
   output logic      [WIDTH-1:0] readVal
);
   // drive only in output mode, pull up only in input mode
   always_comb begin
      outEn    = ~dirInput & digitalOk;
      pullupOn = dirInput & pullupCfg;
      readVal  = (dirInput & pinIn & digitalOk) | (~dirInput & latchVal);
   end
endmodule

// *** ptpc_pkg.sv ***
/*
 port pin control package: register indices, reset values, field widths, structs.
 assumes a plain register port with one-cycle strobes and 8-bit data.
*/
package ptpc_pkg;
   localparam int unsigned DATA_W     = 8;
   localparam int unsigned ADDR_W     = 4;
   localparam int unsigned CHAN_W     = 4;
   // register addresses
   localparam logic [3:0] ADDR_A_DATA   = 4'h0;
   localparam logic [3:0] ADDR_A_DIR    = 4'h1;
   localparam logic [3:0] ADDR_A_CONFIG = 4'h2;
   localparam logic [3:0] ADDR_B_DATA   = 4'h3;
   localparam logic [3:0] ADDR_B_DIR    = 4'h4;
   localparam logic [3:0] ADDR_B_PULLUP = 4'h5;
   localparam logic [3:0] ADDR_ALT_SW   = 4'h6;
   localparam logic [3:0] ADDR_CHAN_SEL = 4'h7;
   // reset values: all inputs, all analog, no pull-ups
   localparam logic [7:0] RST_DIR     = 8'hFF;
   localparam logic [7:0] RST_LATCH   = 8'h00;
   localparam logic [7:0] RST_CONFIG  = 8'h00;
   localparam logic [7:0] RST_PULLUP  = 8'h00;
   localparam logic [7:0] RST_ALT     = 8'h00;
   localparam logic [3:0] RST_CHAN    = 4'h0;
   localparam logic [7:0] READ_ZERO   = 8'h00;
   // port b bit positions of alternate functions
   localparam int unsigned B_IRQ0   = 0;
   localparam int unsigned B_PGCLK  = 1;
   localparam int unsigned B_PGDAT  = 2;
   localparam int unsigned B_TIMER  = 3;
   localparam int unsigned B_TIMALT = 4;
   localparam int unsigned B_SCLK   = 5;
   localparam int unsigned B_SDIN   = 6;
   localparam int unsigned B_SDOUT  = 7;

   // register port request
   typedef struct packed {
      logic                wrStb;
      logic                rdStb;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   wrData;
   } ptpc_req_s;

   // alternate-function outputs into port b (value and enable)
   typedef struct packed {
      logic timerOut;
      logic timerOutEn;
      logic serClkOut;
      logic serClkOutEn;
      logic serDataOut;
      logic serDataOutEn;
      logic toolDataOut;
      logic toolDataOutEn;
   } ptpc_alt_s;
endpackage

// *** ptpc_port_control.sv ***
/*
 port pin control top: analog-capable port a and general port b with alternates.
 assumes a register master per the plain strobe port and an external pad ring.
*/
`timescale 1ns/1ps
// Function
// - digital-configured port a pins act as digital input or latch-driven output.
// - analog, input-mode, channel-selected pin is routed to the converter.
// - unselected analog input stays unconverted; software never sets analog output.
// - reset makes every port a pin an analog input.
// - port b has per-pin latch and per-bit direction.
// - port b pull-up enabled only for input pins with enable bit set.
// - port b carries interrupt, timer, programmer and serial alternate functions.
// - alternate switch reroutes timer input and output to fifth pin.
// - reset places every port b pin in input mode.
// - port a has per-pin latch and per-bit direction.
module ptpc_port_control #(
   parameter int unsigned WIDTH = 8
) (
   // clock and reset
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   // register port
   input  wire ptpc_pkg::ptpc_req_s           req,
   output logic      [WIDTH-1:0]              rdData,
   // port a pads
   input  wire logic [WIDTH-1:0]              portAIn,
   output logic      [WIDTH-1:0]              portAOut,
   output logic      [WIDTH-1:0]              portAOutEn,
   output logic      [WIDTH-1:0]              portAAnalogEn,
   // converter link
   output logic      [ptpc_pkg::CHAN_W-1:0]   convChannel,
   output logic                               convChannelValid,
   // port b pads
   input  wire logic [WIDTH-1:0]              portBIn,
   output logic      [WIDTH-1:0]              portBOut,
   output logic      [WIDTH-1:0]              portBOutEn,
   output logic      [WIDTH-1:0]              portBPullupEn,
   // alternate functions
   input  wire ptpc_pkg::ptpc_alt_s           altIn,
   output logic                               extIrqLevel,
   output logic                               timerInLevel,
   output logic                               programmerClockLevel,
   output logic                               programmerDataLevel,
   output logic                               serClkInLevel,
   output logic                               serDataInLevel
);
   logic [WIDTH-1:0]            aLatch_r;
   logic [WIDTH-1:0]            aDir_r;
   logic [WIDTH-1:0]            aCfg_r;
   logic [WIDTH-1:0]            bLatch_r;
   logic [WIDTH-1:0]            bDir_r;
   logic [WIDTH-1:0]            bPull_r;
   logic                        altSw_r;
   logic [ptpc_pkg::CHAN_W-1:0] chan_r;
   logic [WIDTH-1:0]            aRead;
   logic [WIDTH-1:0]            bRead;
   logic [WIDTH-1:0]            aCellEn;
   logic [WIDTH-1:0]            bCellEn;
   logic [WIDTH-1:0]            aSel;
   logic [WIDTH-1:0]            bAltEn;
   logic [WIDTH-1:0]            bAltVal;
   logic [WIDTH-1:0]            rdData_nxt;

   // one-hot decode of the converter channel
   function automatic logic [WIDTH-1:0] chanOneHot(input logic [ptpc_pkg::CHAN_W-1:0] ch);
      logic [WIDTH-1:0] v;
      v = '0;
      for (int i = 0; i < WIDTH; i++) begin
         if (ch == ptpc_pkg::CHAN_W'(i)) begin
            v[i] = 1'b1;
         end
      end
      return v;
   endfunction

   // write decode helper
   function automatic logic hit(input ptpc_pkg::ptpc_req_s r, input logic [3:0] a);
      return r.wrStb && (r.addr == a);
   endfunction

   // port a registers; reset to analog inputs
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         aLatch_r <= WIDTH'(ptpc_pkg::RST_LATCH);
         aDir_r   <= WIDTH'(ptpc_pkg::RST_DIR);
         aCfg_r   <= WIDTH'(ptpc_pkg::RST_CONFIG);
      end else begin
         if (hit(req, ptpc_pkg::ADDR_A_DATA)) begin
            aLatch_r <= req.wrData[WIDTH-1:0];
         end
         if (hit(req, ptpc_pkg::ADDR_A_DIR)) begin
            aDir_r <= req.wrData[WIDTH-1:0];
         end
         if (hit(req, ptpc_pkg::ADDR_A_CONFIG)) begin
            aCfg_r <= req.wrData[WIDTH-1:0];
         end
      end
   end

   // port b registers; reset to input mode
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bLatch_r <= WIDTH'(ptpc_pkg::RST_LATCH);
         bDir_r   <= WIDTH'(ptpc_pkg::RST_DIR);
         bPull_r  <= WIDTH'(ptpc_pkg::RST_PULLUP);
      end else begin
         if (hit(req, ptpc_pkg::ADDR_B_DATA)) begin
            bLatch_r <= req.wrData[WIDTH-1:0];
         end
         if (hit(req, ptpc_pkg::ADDR_B_DIR)) begin
            bDir_r <= req.wrData[WIDTH-1:0];
         end
         if (hit(req, ptpc_pkg::ADDR_B_PULLUP)) begin
            bPull_r <= req.wrData[WIDTH-1:0];
         end
      end
   end

   // alternate switch and converter channel select
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         altSw_r <= 1'b0;
         chan_r  <= ptpc_pkg::RST_CHAN;
      end else begin
         if (hit(req, ptpc_pkg::ADDR_ALT_SW)) begin
            altSw_r <= req.wrData[0];
         end
         if (hit(req, ptpc_pkg::ADDR_CHAN_SEL)) begin
            chan_r <= req.wrData[ptpc_pkg::CHAN_W-1:0];
         end
      end
   end

   // port a cells: digital only where configured digital
   ptpc_pin_cell #(.WIDTH(WIDTH)) uCellA (
      .dirInput  (aDir_r),
      .latchVal  (aLatch_r),
      .pullupCfg ('0),
      .digitalOk (aCfg_r),
      .pinIn     (portAIn),
      .outEn     (aCellEn),
      .pullupOn  (),
      .readVal   (aRead)
   );

   // port b cells: always digital
   ptpc_pin_cell #(.WIDTH(WIDTH)) uCellB (
      .dirInput  (bDir_r),
      .latchVal  (bLatch_r),
      .pullupCfg (bPull_r),
      .digitalOk ('1),
      .pinIn     (portBIn),
      .outEn     (bCellEn),
      .pullupOn  (portBPullupEn),
      .readVal   (bRead)
   );

   // port a pad and converter routing
   always_comb begin
      aSel             = chanOneHot(chan_r);
      portAOut         = aLatch_r;
      portAOutEn       = aCellEn;
      portAAnalogEn    = ~aCfg_r & aDir_r;
      convChannel      = chan_r;
      convChannelValid = |(aSel & ~aCfg_r & aDir_r);
   end

   // port b alternate output multiplexer; timer moves to fifth pin when switched
   always_comb begin
      bAltEn  = '0;
      bAltVal = '0;
      bAltEn[B_TIM_IDX(altSw_r)]  = altIn.timerOutEn;
      bAltVal[B_TIM_IDX(altSw_r)] = altIn.timerOut;
      bAltEn[ptpc_pkg::B_SCLK]    = altIn.serClkOutEn;
      bAltVal[ptpc_pkg::B_SCLK]   = altIn.serClkOut;
      bAltEn[ptpc_pkg::B_SDOUT]   = altIn.serDataOutEn;
      bAltVal[ptpc_pkg::B_SDOUT]  = altIn.serDataOut;
      bAltEn[ptpc_pkg::B_PGDAT]   = altIn.toolDataOutEn;
      bAltVal[ptpc_pkg::B_PGDAT]  = altIn.toolDataOut;
      portBOutEn = bCellEn | bAltEn;
      portBOut   = (bAltEn & bAltVal) | (~bAltEn & bLatch_r);
   end

   // timer pin index chosen by the alternate switch
   function automatic int unsigned B_TIM_IDX(input logic sw);
      return sw ? ptpc_pkg::B_TIMALT : ptpc_pkg::B_TIMER;
   endfunction

   // alternate input taps from port b pads
   always_comb begin
      extIrqLevel          = portBIn[ptpc_pkg::B_IRQ0];
      timerInLevel         = portBIn[B_TIM_IDX(altSw_r)];
      programmerClockLevel = portBIn[ptpc_pkg::B_PGCLK];
      programmerDataLevel  = portBIn[ptpc_pkg::B_PGDAT];
      serClkInLevel        = portBIn[ptpc_pkg::B_SCLK];
      serDataInLevel       = portBIn[ptpc_pkg::B_SDIN];
   end

   // read multiplexer; unmapped addresses read zero
   always_comb begin
      case (req.addr)
         ptpc_pkg::ADDR_A_DATA:   rdData_nxt = aRead;
         ptpc_pkg::ADDR_A_DIR:    rdData_nxt = aDir_r;
         ptpc_pkg::ADDR_A_CONFIG: rdData_nxt = aCfg_r;
         ptpc_pkg::ADDR_B_DATA:   rdData_nxt = bRead;
         ptpc_pkg::ADDR_B_DIR:    rdData_nxt = bDir_r;
         ptpc_pkg::ADDR_B_PULLUP: rdData_nxt = bPull_r;
         ptpc_pkg::ADDR_ALT_SW:   rdData_nxt = {{(WIDTH-1){1'b0}}, altSw_r};
         ptpc_pkg::ADDR_CHAN_SEL: rdData_nxt = {{(WIDTH-ptpc_pkg::CHAN_W){1'b0}}, chan_r};
         default:                 rdData_nxt = WIDTH'(ptpc_pkg::READ_ZERO);
      endcase
   end

   // read data registered one cycle after the strobe, zero otherwise
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdData <= WIDTH'(ptpc_pkg::READ_ZERO);
      end else if (req.rdStb) begin
         rdData <= rdData_nxt;
      end else begin
         rdData <= WIDTH'(ptpc_pkg::READ_ZERO);
      end
   end
endmodule

// *** ptpc_port_control_chk.sv ***
/* checker for port pin control: register, pad and converter relations.
   assumes a bind to ptpc_port_control, one clk and reset_n domain. */
`timescale 1ns/1ps
module ptpc_port_control_chk #(
   parameter int unsigned WIDTH = 8
) (
   // clock and reset
   input wire logic                clk,
   input wire logic                reset_n,
   // register port
   input wire ptpc_pkg::ptpc_req_s req,
   input wire logic [WIDTH-1:0]    rdData,
   // pads, converter, alternates
   input wire logic [WIDTH-1:0]    portAOut,
   input wire logic [WIDTH-1:0]    portAOutEn,
   input wire logic [WIDTH-1:0]    portAAnalogEn,
   input wire logic [3:0]          convChannel,
   input wire logic                convChannelValid,
   input wire logic [WIDTH-1:0]    portBIn,
   input wire logic [WIDTH-1:0]    portBOutEn,
   input wire logic [WIDTH-1:0]    portBPullupEn,
   input wire ptpc_pkg::ptpc_alt_s altIn,
   input wire logic                extIrqLevel,
   input wire logic                timerInLevel,
   input wire logic                serClkInLevel
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // read data only in the slot after a read strobe
   property p_rd_gap; rdData != 8'h00 |-> $past(req.rdStb); endproperty
   a_rd_gap: assert property (p_rd_gap) else $error("read data outside read slot");
   property p_a_latch; req.wrStb && req.addr == 4'h0 |=> portAOut == $past(req.wrData); endproperty
   a_a_latch: assert property (p_a_latch) else $error("port a latch not written");
   property p_b_dir;
      (req.wrStb && req.addr == 4'h4 && altIn == 8'h00 ##1 altIn == 8'h00) |-> portBOutEn == ~$past(req.wrData);
   endproperty
   a_b_dir: assert property (p_b_dir) else $error("port b direction wrong");
   property p_pull; req.wrStb && req.addr == 4'h5 |=> (portBPullupEn & ~$past(req.wrData)) == 8'h00; endproperty
   a_pull: assert property (p_pull) else $error("pull-up without enable bit");
   property p_excl; (portAOutEn & portAAnalogEn) == 8'h00; endproperty
   a_excl: assert property (p_excl) else $error("analog pin driven");
   property p_chan; convChannelValid == (convChannel < 4'h8 && portAAnalogEn[convChannel[2:0]]); endproperty
   a_chan: assert property (p_chan) else $error("channel valid mismatch");
   property p_alt_in; extIrqLevel == portBIn[0] && serClkInLevel == portBIn[5]; endproperty
   a_alt_in: assert property (p_alt_in) else $error("alternate input level wrong");
   property p_timer; req.wrStb && req.addr == 4'h6 |=> timerInLevel == portBIn[$past(req.wrData[0]) ? 4 : 3]; endproperty
   a_timer: assert property (p_timer) else $error("timer input pin wrong");
   property p_reset; $rose(reset_n) |-> portAAnalogEn == 8'hFF && portAOutEn == 8'h00; endproperty
   a_reset: assert property (p_reset) else $error("port a not analog after reset");
   // main scenarios
   c_read: cover property (req.rdStb ##1 rdData != 8'h00);
   c_conv: cover property (convChannelValid && portAAnalogEn != 8'hFF);
   c_sw: cover property (req.wrStb && req.addr == 4'h6 && req.wrData[0]);
endmodule
bind ptpc_port_control ptpc_port_control_chk #(.WIDTH(WIDTH)) u_chk (.clk, .reset_n, .req, .rdData, .portAOut,
   .portAOutEn, .portAAnalogEn, .convChannel, .convChannelValid, .portBIn, .portBOutEn, .portBPullupEn, .altIn,
   .extIrqLevel, .timerInLevel, .serClkInLevel);

// *** ptpc_port_control_tb.sv ***
/* self-checking bench for port pin control, register calls and pad checks.
   assumes the far-side model resolves pads; no random stimulus. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; $display("ERROR %s exp %h got %h", n, e, g); end end
module ptpc_port_control_tb;
   logic                clk, reset_n, convChannelValid, convSample;
   ptpc_pkg::ptpc_req_s req;
   ptpc_pkg::ptpc_alt_s altIn;
   logic [7:0]          rdData, portAIn, portAOut, portAOutEn, portAAnalogEn, extA, extB;
   logic [7:0]          portBIn, portBOut, portBOutEn, portBPullupEn;
   logic [3:0]          convChannel;
   logic                extIrqLevel, timerInLevel, programmerClockLevel, programmerDataLevel;
   logic                serClkInLevel, serDataInLevel;
   int                  fails, check_count;
   ptpc_port_control dut (.clk(clk), .reset_n(reset_n), .req(req), .rdData(rdData), .portAIn(portAIn),
      .portAOut(portAOut), .portAOutEn(portAOutEn), .portAAnalogEn(portAAnalogEn), .convChannel(convChannel),
      .convChannelValid(convChannelValid), .portBIn(portBIn), .portBOut(portBOut), .portBOutEn(portBOutEn),
      .portBPullupEn(portBPullupEn), .altIn(altIn), .extIrqLevel(extIrqLevel), .timerInLevel(timerInLevel),
      .programmerClockLevel(programmerClockLevel), .programmerDataLevel(programmerDataLevel),
      .serClkInLevel(serClkInLevel), .serDataInLevel(serDataInLevel));
   ptpc_far_side far (.clk(clk), .portAOut(portAOut), .portAOutEn(portAOutEn), .portBOut(portBOut),
      .portBOutEn(portBOutEn), .extA(extA), .extB(extB), .convChannel(convChannel),
      .convChannelValid(convChannelValid), .portAIn(portAIn), .portBIn(portBIn), .convSample(convSample));
   // clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // one-cycle write, outputs settled on return
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{wrStb: 1'b1, rdStb: 1'b0, addr: a, wrData: d};
      @(posedge clk);
      req <= '0;
      #1;
   endtask
   // one-cycle read, data compared in the following cycle
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      req <= '{wrStb: 1'b0, rdStb: 1'b1, addr: a, wrData: 8'h00};
      @(posedge clk);
      req <= '0;
      #1;
      `CHK("rdData", e, rdData)
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      tally_and_finish();
   end
   // main sequence
   initial begin
      reset_n = 1'b0;
      req = '0;
      altIn = '0;
      extA = 8'h00;
      extB = 8'h00;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      #1;
      `CHK("portAAnalogEn", 8'hFF, portAAnalogEn)
      `CHK("portBOutEn", 8'h00, portBOutEn)
      rd(4'h1, 8'hFF);
      rd(4'h2, 8'h00);
      rd(4'h4, 8'hFF);
      rd(4'h5, 8'h00);
      rd(4'h8, 8'h00);
      $display("test reset done");
      // digital port a, channel parked off the port
      extA = 8'h3C;
      wr(4'h2, 8'hFF);
      wr(4'h7, 8'h0F);
      wr(4'h1, 8'h0F);
      wr(4'h0, 8'hA5);
      `CHK("portAOut", 8'hA5, portAOut)
      `CHK("portAOutEn", 8'hF0, portAOutEn)
      `CHK("convChannelValid", 1'b0, convChannelValid)
      rd(4'h0, 8'hAC);
      $display("test digital a done");
      // upper half analog inputs, never analog outputs
      extA = 8'h4F;
      wr(4'h1, 8'hFF);
      wr(4'h2, 8'h0F);
      wr(4'h7, 8'h06);
      `CHK("convChannelValid", 1'b1, convChannelValid)
      `CHK("convChannel", 4'h6, convChannel)
      `CHK("portAAnalogEn", 8'hF0, portAAnalogEn)
      rd(4'h0, 8'h0F);
      `CHK("convSample", 1'b1, convSample)
      $display("test analog a done");
      // port b direction, pull-ups and readback
      extB = 8'hC3;
      wr(4'h4, 8'h0F);
      wr(4'h5, 8'hFF);
      wr(4'h3, 8'h5A);
      `CHK("portBOutEn", 8'hF0, portBOutEn)
      `CHK("portBPullupEn", 8'h0F, portBPullupEn)
      `CHK("portBOut", 8'h5A, portBOut)
      rd(4'h3, 8'h53);
      $display("test port b done");
      // timer rerouting and alternate inputs
      extB = 8'h11;
      wr(4'h4, 8'hFF);
      `CHK("timerInLevel", 1'b0, timerInLevel)
      `CHK("extIrqLevel", 1'b1, extIrqLevel)
      // every alternate input tap except the timer follows its own pad
      extB = 8'h66;
      #1;
      `CHK("extIrqLevel", 1'b0, extIrqLevel)
      `CHK("programmerClockLevel", 1'b1, programmerClockLevel)
      `CHK("programmerDataLevel", 1'b1, programmerDataLevel)
      `CHK("serClkInLevel", 1'b1, serClkInLevel)
      `CHK("serDataInLevel", 1'b1, serDataInLevel)
      extB = 8'h11;
      wr(4'h6, 8'h01);
      `CHK("timerInLevel", 1'b1, timerInLevel)
      @(posedge clk);
      altIn <= '{timerOut: 1'b1, timerOutEn: 1'b1, default: 1'b0};
      #1;
      `CHK("portBOutEn", 8'h10, portBOutEn)
      wr(4'h6, 8'h00);
      `CHK("portBOutEn", 8'h08, portBOutEn)
      `CHK("portBOut bit3", 1'b1, portBOut[3])
      // all alternate outputs take their pins over the latch
      @(posedge clk);
      altIn <= '{timerOut: 1'b0, default: 1'b1};
      #1;
      `CHK("portBOutEn", 8'hAC, portBOutEn)
      `CHK("portBOut", 8'hF6, portBOut)
      $display("test alternates done");
      // mid-run reset returns both ports to their reset state
      @(posedge clk);
      altIn <= '0;
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      #1;
      `CHK("portAAnalogEn", 8'hFF, portAAnalogEn)
      `CHK("portBOutEn", 8'h00, portBOutEn)
      `CHK("portAOut", 8'h00, portAOut)
      rd(4'h2, 8'h00);
      rd(4'h5, 8'h00);
      $display("test mid-run reset done");
      tally_and_finish();
   end
endmodule
